// File: src/asc_core.sv
// Functional notes
// RL1 - tx empty flag set when buffer free
// RL2 - write during frame waits in buffer
// RL3 - idle write loads shifter, flag stays set
// RL4 - tx idle set after stop or break
// RL5 - status read then write clears tx flags
// RL6 - break armed after held over divisor+1 clocks
// RL7 - break is start plus 13N zeros, then stop
// RL8 - break frames raise no tx interrupt
// RL9 - ninth bit to control field, lsb first
// RL10 - 16x oversampling, three-sample majority vote
// RL11 - after stop, word moves to buffer
// RL12 - two words held, third discarded on overrun
// RL13 - overrun flag and irq, cleared by sequence
// RL14 - rx available flag, irq per transfer
// RL15 - status then buffer read clears rx available
// RL16 - break gives zero word with framing flag
// RL17 - after framing error wait for high line
// RL18 - rx idle low from start to stop
// RL19 - noise flag set with data, no irq
// RL20 - zero at stop bit sets framing flag
// RL21 - parity error stored with the word
// RL22 - software reads error flags before data
// RL23 - tx line rests high between frames
// RL24 - disable empties buffers, resets flags
// RL25 - votes at ticks 7..9, start confirmed mid-bit
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "asc_cfg.svh"
module asc_core
   import asc_pkg::*;
#(
   parameter int ADDR_W = 32
) (
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write channels
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // axi4-lite read channels
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // serial pins
   input  wire logic              rx_pin,
   output logic                   tx_pin,
   // interrupt requests
   output logic                   tx_irq,
   output logic                   rx_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // parameter check
   if (ADDR_W < 5) begin : g_chk
      $error("ADDR_W must be at least 5");
   end

   asc_state_t  r;
   asc_state_t  n;
   logic        aw_hs, w_hs, ar_hs, wr_do, rd_stat, rd_data, wr_data_ev;
   logic [32:0] rd_v, old_v;
   logic [31:0] wmask, wval;
   logic        brk_ok, tx_end, rx_mid, rx_end, vote, noisy, push, pop;
   logic [3:0]  nbm1;
   logic [8:0]  wword;
   logic [1:0]  cnt_ap;
   asc_word_t   word;

   // register readback for one address, top bit marks a hit
   function automatic logic [32:0] rd_mux(input asc_state_t s, input logic [3:0] a);
      logic [32:0] v;
      v = {1'b1, 32'h0000_0000};
      case (a)
         `ASC_OFF_CTRL: begin
            v[`ASC_C_EN]    = s.en;
            v[`ASC_C_TXEN]  = s.txen;
            v[`ASC_C_RECEIVER_ENABLE_BIT]  = s.receiver_enable_bit;
            v[`ASC_C_NINE]  = s.nine;
            v[`ASC_C_PARITY_ENABLE]  = s.parity_enable;
            v[`ASC_C_ODD]   = s.odd;
            v[`ASC_C_STOP2] = s.stop2;
            v[`ASC_C_BRK]   = s.brk;
            v[`ASC_C_TX8]   = s.tx8;
            v[`ASC_C_RX8]   = s.fifo[0].d[8]; // RL9
            v[`ASC_C_TX_EMPTY_IRQ_ENABLE]  = s.tx_empty_irq_enable;
            v[`ASC_C_RIE]   = s.rx_irq_enable;
         end
         `ASC_OFF_STAT: begin
            v[`ASC_S_PARITY_ERROR_FLAG]  = (s.fcnt != 2'h0) & s.fifo[0].parity_error_flag; // RL21
            v[`ASC_S_NF]    = (s.fcnt != 2'h0) & s.fifo[0].nf;
            v[`ASC_S_FRAMING_ERROR_FLAG]  = (s.fcnt != 2'h0) & s.fifo[0].framing_error_flag;
            v[`ASC_S_OVR]   = s.ovr;
            v[`ASC_S_RX_IDLE_FLAG] = s.rx_idle_flag;
            v[`ASC_S_RX_DATA_AVAILABLE_FLAG]  = (s.fcnt != 2'h0); // RL14
            v[`ASC_S_TX_IDLE_FLAG] = s.tx_idle_flag;
            v[`ASC_S_TX_BUFFER_EMPTY_FLAG]  = s.txe; // RL1
         end
         `ASC_OFF_DATA: v[7:0] = s.fifo[0].d[7:0];
         `ASC_OFF_BAUD: v[7:0] = s.div;
         default:       v[32] = 1'b0;
      endcase
      return v;
   endfunction

   // bus handshakes, combinational
   assign awready = !r.aw_got && !r.bvalid;
   assign wready  = !r.w_got && !r.bvalid;
   assign arready = !r.rvalid;
   assign bvalid  = r.bvalid;
   assign bresp   = r.bresp;
   assign rvalid  = r.rvalid;
   assign rresp   = r.rresp;
   assign rdata   = r.rdata;
   assign tx_pin  = r.tx_line;
   assign tx_irq  = r.tx_irq;
   assign rx_irq  = r.rx_irq;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      n          = r;
      n.tick     = 1'b0;
      n.rx_irq   = 1'b0;
      rd_stat    = 1'b0;
      rd_data    = 1'b0;
      wr_data_ev = 1'b0;
      push       = 1'b0;
      word       = '0;
      rd_v       = '0;
      // bus slave: latch address and data in either order
      aw_hs = awvalid && awready;
      w_hs  = wvalid && wready;
      ar_hs = arvalid && arready;
      if (aw_hs) begin
         n.aw_got = 1'b1;
         n.waddr  = awaddr[3:0];
         n.whi    = |awaddr[ADDR_W-1:4];
      end
      if (w_hs) begin
         n.w_got = 1'b1;
         n.wdata = wdata;
         n.wstrb = wstrb;
      end
      if (r.bvalid && bready) n.bvalid = 1'b0;
      if (r.rvalid && rready) n.rvalid = 1'b0;
      for (int i = 0; i < 4; i++) begin
         wmask[8*i +: 8] = {8{r.wstrb[i]}};
      end
      old_v = rd_mux(r, r.waddr);
      wval  = (r.wdata & wmask) | (old_v[31:0] & ~wmask);
      wword = {r.nine & r.tx8, r.wdata[7:0]};
      wr_do = r.aw_got && r.w_got;
      if (wr_do) begin
         n.aw_got = 1'b0;
         n.w_got  = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = (old_v[32] && !r.whi) ? `ASC_RESP_OK : `ASC_RESP_ERR;
         if (!r.whi) begin
            case (r.waddr)
               `ASC_OFF_CTRL: begin
                  n.en    = wval[`ASC_C_EN];
                  n.txen  = wval[`ASC_C_TXEN];
                  n.receiver_enable_bit  = wval[`ASC_C_RECEIVER_ENABLE_BIT];
                  n.nine  = wval[`ASC_C_NINE];
                  n.parity_enable  = wval[`ASC_C_PARITY_ENABLE];
                  n.odd   = wval[`ASC_C_ODD];
                  n.stop2 = wval[`ASC_C_STOP2];
                  n.brk   = wval[`ASC_C_BRK];
                  n.tx8   = wval[`ASC_C_TX8];
                  n.tx_empty_irq_enable  = wval[`ASC_C_TX_EMPTY_IRQ_ENABLE];
                  n.rx_irq_enable   = wval[`ASC_C_RIE];
               end
               `ASC_OFF_DATA: wr_data_ev = r.wstrb[0];
               `ASC_OFF_BAUD: n.div = wval[7:0];
               default: ;
            endcase
         end
      end
      if (ar_hs) begin
         rd_v    = rd_mux(r, araddr[3:0]);
         n.rvalid = 1'b1;
         n.rdata  = (rd_v[32] && !(|araddr[ADDR_W-1:4])) ? rd_v[31:0] : 32'h0000_0000;
         n.rresp  = (rd_v[32] && !(|araddr[ADDR_W-1:4])) ? `ASC_RESP_OK : `ASC_RESP_ERR;
         rd_stat  = rd_v[32] && !(|araddr[ADDR_W-1:4]) && (araddr[3:0] == `ASC_OFF_STAT);
         rd_data  = rd_v[32] && !(|araddr[ADDR_W-1:4]) && (araddr[3:0] == `ASC_OFF_DATA);
      end
      // status read arms the next data access
      n.armed = rd_stat || (r.armed && !(rd_data || wr_data_ev)); // RL5 RL15

      // baud divider gives the 16x tick
      if (r.en && r.bcnt == r.div) begin
         n.bcnt = `ASC_BAUD_RST;
         n.tick = 1'b1; // RL10
      end else if (r.en) begin
         n.bcnt = r.bcnt + 8'h01;
      end else begin
         n.bcnt = `ASC_BAUD_RST;
      end
      // break control must stay set beyond divisor+1 clocks
      if (r.brk && r.txen) n.hold = (r.hold == 9'h1ff) ? r.hold : r.hold + 9'h001;
      else n.hold = 9'h000;
      brk_ok = r.hold > ({1'b0, r.div} + 9'h001); // RL6
      nbm1   = r.nine ? `ASC_NB9_LAST : `ASC_NB8_LAST;

      // transmitter
      tx_end = r.tick && (r.tx_sub == `ASC_SUB_LAST);
      if (r.tick && r.tx_st != TX_IDLE) n.tx_sub = r.tx_sub + 4'h1;
      case (r.tx_st)
         TX_IDLE: begin
            n.tx_sub  = 4'h0;
            n.tx_line = 1'b1; // RL23
            if (r.txen && brk_ok) begin
               n.tx_st  = TX_START;
               n.tx_brk = 1'b1;
               n.tx_idle_flag  = 1'b0; // RL8
            end else if (r.txen && !r.txe) begin
               n.tx_sh  = r.tx_buf; // RL2
               n.tx_par = ^r.tx_buf ^ r.odd;
               n.tx_brk = 1'b0;
               n.tx_st  = TX_START;
               n.txe    = 1'b1; // RL1
               n.tx_idle_flag  = 1'b0;
            end
         end
         TX_START: begin
            n.tx_line = 1'b0;
            n.tx_cnt  = 4'h0;
            if (tx_end) n.tx_st = r.tx_brk ? TX_BRK : TX_DATA;
         end
         TX_DATA: begin
            n.tx_line = r.tx_sh[0];
            if (tx_end) begin
               n.tx_sh  = {1'b0, r.tx_sh[8:1]};
               n.tx_cnt = r.tx_cnt + 4'h1;
               if (r.tx_cnt == nbm1) begin
                  n.tx_st  = r.parity_enable ? TX_PAR : TX_STOP;
                  n.tx_cnt = 4'h0;
               end
            end
         end
         TX_PAR: begin
            n.tx_line = r.tx_par;
            if (tx_end) n.tx_st = TX_STOP;
         end
         TX_STOP: begin
            n.tx_line = 1'b1;
            if (tx_end && r.stop2 && r.tx_cnt == 4'h0) begin
               n.tx_cnt = 4'h1;
            end else if (tx_end) begin
               n.tx_st  = TX_IDLE;
               n.tx_idle_flag  = 1'b1; // RL4
               n.tx_brk = 1'b0;
            end
         end
         TX_BRK: begin
            n.tx_line = 1'b0;
            if (tx_end) begin
               n.tx_cnt = r.tx_cnt + 4'h1;
               if (r.tx_cnt == `ASC_BRK_LAST) begin
                  n.tx_cnt = 4'h0; // RL7
                  if (!r.brk) n.tx_st = TX_STOP;
               end
            end
         end
         default: n.tx_st = TX_IDLE;
      endcase
      // armed data write: direct load when idle, else hold in buffer
      if (wr_data_ev && r.armed && r.txe) begin
         n.tx_idle_flag = 1'b0; // RL5
         if (r.txen && r.tx_st == TX_IDLE && !brk_ok) begin
            n.tx_sh  = wword; // RL3
            n.tx_par = ^wword ^ r.odd;
            n.tx_brk = 1'b0;
            n.tx_st  = TX_START;
            n.txe    = 1'b1;
         end else begin
            n.tx_buf = wword; // RL2
            n.txe    = 1'b0;
         end
      end
      if (!r.txen) begin
         n.tx_st   = TX_IDLE;
         n.tx_line = 1'b1;
      end

      // receiver: two-flop synchroniser, majority vote at ticks 7..9
      n.rx_s1 = rx_pin;
      n.rx_s2 = r.rx_s1;
      rx_mid  = r.tick && (r.rx_sub == `ASC_SMP_C);
      rx_end  = r.tick && (r.rx_sub == `ASC_SUB_LAST);
      vote    = (r.smp[0] & r.smp[1]) | (r.smp[0] & r.rx_s2) | (r.smp[1] & r.rx_s2); // RL25
      noisy   = !((r.smp[0] == r.smp[1]) && (r.smp[1] == r.rx_s2));
      if (r.tick && r.rx_st != RX_IDLE && r.rx_st != RX_WAIT) n.rx_sub = r.rx_sub + 4'h1;
      if (r.tick && r.rx_sub == `ASC_SMP_A) n.smp[0] = r.rx_s2;
      if (r.tick && r.rx_sub == `ASC_SMP_B) n.smp[1] = r.rx_s2;
      if (rx_mid && noisy) n.rx_nf = 1'b1; // RL19
      case (r.rx_st)
         RX_IDLE: begin
            n.rx_idle_flag = 1'b1;
            if (!r.rx_s2) begin
               n.rx_st   = RX_START;
               n.rx_sub  = 4'h0;
               n.rx_nf   = 1'b0;
               n.rx_parity_error_flag = 1'b0;
               n.rx_par  = 1'b0;
               n.rx_idle_flag   = 1'b0; // RL18
            end
         end
         RX_START: begin
            n.rx_cnt = 4'h0;
            if (rx_mid && vote) begin
               n.rx_st = RX_IDLE; // RL25
               n.rx_idle_flag = 1'b1;
            end else if (rx_end) begin
               n.rx_st = RX_DATA;
            end
         end
         RX_DATA: begin
            if (rx_mid) begin
               n.rx_sh  = {vote, r.rx_sh[8:1]}; // RL9
               n.rx_par = r.rx_par ^ vote;
            end
            if (rx_end) begin
               n.rx_cnt = r.rx_cnt + 4'h1;
               if (r.rx_cnt == nbm1) begin
                  n.rx_st  = r.parity_enable ? RX_PAR : RX_STOP;
                  n.rx_cnt = 4'h0;
               end
            end
         end
         RX_PAR: begin
            if (rx_mid) n.rx_parity_error_flag = r.rx_par ^ vote ^ r.odd; // RL21
            if (rx_end) n.rx_st = RX_STOP;
         end
         RX_STOP: begin
            if (rx_mid && r.stop2 && vote && r.rx_cnt == 4'h0) begin
               n.rx_cnt = 4'h1; // RL20
            end else if (rx_mid) begin
               push      = 1'b1; // RL11
               word.d    = r.nine ? r.rx_sh : {1'b0, r.rx_sh[8:1]};
               word.framing_error_flag = !vote; // RL20 RL16
               word.parity_error_flag = r.rx_parity_error_flag;
               word.nf   = r.rx_nf || noisy;
               n.rx_st   = vote ? RX_IDLE : RX_WAIT; // RL17
               n.rx_idle_flag   = 1'b1;
            end
         end
         RX_WAIT: begin
            if (r.rx_s2) n.rx_st = RX_IDLE; // RL17
         end
         default: n.rx_st = RX_IDLE;
      endcase
      if (!r.receiver_enable_bit) begin
         n.rx_st = RX_IDLE;
         n.rx_idle_flag = 1'b1;
      end
      // two-word receive buffer, head at entry 0
      pop    = rd_data && r.armed && (r.fcnt != 2'h0); // RL15
      cnt_ap = r.fcnt - {1'b0, pop};
      if (pop) n.fifo[0] = r.fifo[1];
      if (rd_data && r.armed) n.ovr = 1'b0;
      if (push) begin
         if (cnt_ap == 2'h2) begin
            n.ovr = 1'b1; // RL12 RL13
         end else begin
            n.fifo[cnt_ap[0]] = word;
            cnt_ap = cnt_ap + 2'h1;
         end
         n.rx_irq = r.rx_irq_enable; // RL14 RL13
      end
      n.fcnt = cnt_ap;

      // port disable: flush and force the documented flag values
      if (!n.en) begin
         n.txen    = 1'b0; // RL24
         n.receiver_enable_bit    = 1'b0;
         n.brk     = 1'b0;
         n.hold    = 9'h000;
         n.tx_st   = TX_IDLE;
         n.tx_line = 1'b1;
         n.txe     = 1'b1;
         n.tx_idle_flag   = 1'b1;
         n.rx_st   = RX_IDLE;
         n.rx_idle_flag   = 1'b1;
         n.fcnt    = 2'h0;
         n.ovr     = 1'b0;
         n.rx_irq  = 1'b0;
      end
      n.tx_irq = n.txe && n.tx_empty_irq_enable; // RL1
      if (!aresetn) begin
         n         = '0;
         n.txe     = 1'b1;
         n.tx_idle_flag   = 1'b1;
         n.rx_idle_flag   = 1'b1;
         n.tx_line = 1'b1;
         n.rx_s1   = 1'b1;
         n.rx_s2   = 1'b1;
      end
   end

   // state register
   always_ff @(posedge aclk) begin
      r <= n;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   tx_rest_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL23
      $past(r.tx_st) == TX_IDLE && r.tx_st == TX_IDLE |-> tx_pin)
      else $error("tx line not high while idle");
   txe_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
      $fell(r.txe) |-> $past(wr_data_ev && r.armed))
      else $error("tx empty cleared without sequence");
   brk_line_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
      r.tx_st == TX_BRK ##1 r.tx_st == TX_BRK |-> !tx_pin)
      else $error("break frame not low");
   txe_rise_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
      $rose(r.txe) |-> $past(r.tx_st == TX_IDLE || !n.en))
      else $error("tx empty rose outside a data load");
   direct_load_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
      wr_data_ev && r.armed && r.txe && r.txen && r.en && r.tx_st == TX_IDLE && !brk_ok
      |=> r.tx_st == TX_START && r.txe ##1 !tx_pin)
      else $error("idle write did not start a frame");
   overrun_keep_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
      push && r.fcnt == 2'h2 && !pop && n.en |=> r.ovr && r.fcnt == 2'h2 && $stable(r.fifo))
      else $error("overrun lost buffered words");
   rx_push_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL14
      push && r.rx_irq_enable && n.en |=> rx_irq && r.fcnt != 2'h0 ##1 !rx_irq)
      else $error("transfer without flag or irq pulse");
   rx_data_available_flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL15
      $fell(r.fcnt != 2'h0) |-> $past(pop || !n.en))
      else $error("rx available cleared without sequence");
   rx_idle_flag_busy_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL18
      r.rx_st inside {RX_DATA, RX_PAR} |-> !r.rx_idle_flag)
      else $error("rx idle high during frame");
   brk_wait_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL17
      r.rx_st == RX_WAIT && !r.rx_s2 && r.receiver_enable_bit && n.en |=> r.rx_st == RX_WAIT && !push)
      else $error("receiver left wait on low line");
   disable_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL24
      !r.en |-> r.txe && r.tx_idle_flag && r.rx_idle_flag && r.fcnt == 2'h0 && !r.txen && !r.receiver_enable_bit)
      else $error("disabled port not flushed");

endmodule

// File: src/asc_cfg.svh
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH
// register byte offsets
`define ASC_OFF_CTRL  4'h0
`define ASC_OFF_STAT  4'h4
`define ASC_OFF_DATA  4'h8
`define ASC_OFF_BAUD  4'hc
// bus responses
`define ASC_RESP_OK   2'h0
`define ASC_RESP_ERR  2'h2
// control register bit positions
`define ASC_C_EN      0
`define ASC_C_TXEN    1
`define ASC_C_RECEIVER_ENABLE_BIT    2
`define ASC_C_NINE    3
`define ASC_C_PARITY_ENABLE    4
`define ASC_C_ODD     5
`define ASC_C_STOP2   6
`define ASC_C_BRK     7
`define ASC_C_TX8     8
`define ASC_C_RX8     9
`define ASC_C_TX_EMPTY_IRQ_ENABLE    10
`define ASC_C_RIE     11
// status register bit positions
`define ASC_S_PARITY_ERROR_FLAG    0
`define ASC_S_NF      1
`define ASC_S_FRAMING_ERROR_FLAG    2
`define ASC_S_OVR     3
`define ASC_S_RX_IDLE_FLAG   4
`define ASC_S_RX_DATA_AVAILABLE_FLAG    5
`define ASC_S_TX_IDLE_FLAG   6
`define ASC_S_TX_BUFFER_EMPTY_FLAG    7
// oversampling and frame counts
`define ASC_SUB_LAST  4'hf
`define ASC_SMP_A     4'h7
`define ASC_SMP_B     4'h8
`define ASC_SMP_C     4'h9
`define ASC_BRK_LAST  4'hc
`define ASC_NB8_LAST  4'h7
`define ASC_NB9_LAST  4'h8
`define ASC_BAUD_RST  8'h00
`endif

// File: src/asc_pkg.sv
package asc_pkg;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK} asc_tx_st_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT} asc_rx_st_t;
   // one received word with its error marks
   typedef struct packed {
      logic       parity_error_flag;
      logic       framing_error_flag;
      logic       nf;
      logic [8:0] d;
   } asc_word_t;
   // whole state of the core
   typedef struct packed {
      logic en, txen, receiver_enable_bit, nine, parity_enable, odd, stop2, brk, tx8, tx_empty_irq_enable, rx_irq_enable;
      logic [7:0]       div;
      logic             aw_got, w_got, whi;
      logic [3:0]       waddr;
      logic [31:0]      wdata;
      logic [3:0]       wstrb;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             rvalid;
      logic [1:0]       rresp;
      logic [31:0]      rdata;
      logic             armed;
      logic [7:0]       bcnt;
      logic             tick;
      logic [8:0]       hold;
      asc_tx_st_t       tx_st;
      logic [3:0]       tx_sub, tx_cnt;
      logic [8:0]       tx_sh, tx_buf;
      logic             tx_par, tx_brk, tx_line, txe, tx_idle_flag, tx_irq;
      asc_rx_st_t       rx_st;
      logic             rx_s1, rx_s2;
      logic [3:0]       rx_sub, rx_cnt;
      logic [8:0]       rx_sh;
      logic [1:0]       smp;
      logic             rx_par, rx_parity_error_flag, rx_nf, rx_idle_flag, rx_irq;
      asc_word_t [1:0]  fifo;
      logic [1:0]       fcnt;
      logic             ovr;
   } asc_state_t;
endpackage

// File: tb/asc_peer.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// remote serial node, 16 clocks per bit (divisor 0)
module asc_peer (
   // clock
   input  wire logic aclk,
   // serial lines
   input  wire logic tx_pin,
   output logic      rx_pin
);
   logic [8:0] got[$];
   logic [8:0] w;

   initial rx_pin = 1'b1;

   // capture each frame of the core mid-bit, stop level in bit 8
   always begin
      @(negedge tx_pin);
      repeat (8) @(posedge aclk);
      for (int i = 0; i < 9; i++) begin
         repeat (16) @(posedge aclk);
         w[i] = tx_pin;
      end
      got.push_back(w);
      wait (tx_pin);
   end

   ////////////////////////////////////////////////////////////
   // send one frame lsb first; line returns high afterwards
   task automatic send(input logic [7:0] d, input logic stp);
      logic [9:0] f;
      f = {stp, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rx_pin <= f[i];
         repeat (16) @(posedge aclk);
      end
      rx_pin <= 1'b1;
      repeat (32) @(posedge aclk);
   endtask
endmodule

// File: tb/tb_async_serial_tx_rx_core.sv
`timescale 1ns/1ps
`include "asc_cfg.svh"
module tb_async_serial_tx_rx_core;
   import asc_pkg::*;
   localparam logic [31:0] A_CTRL = {28'h0000000, `ASC_OFF_CTRL};
   localparam logic [31:0] A_STAT = {28'h0000000, `ASC_OFF_STAT};
   localparam logic [31:0] A_DATA = {28'h0000000, `ASC_OFF_DATA};
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, rx_pin, tx_pin, tx_irq, rx_irq;
   logic [31:0] awaddr, araddr, wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   int          bad_count, num_checks, irq_n, n0, low_run, low_last;

   asc_core i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_irq(tx_irq), .rx_irq(rx_irq));
   asc_peer i_peer (.aclk(aclk), .tx_pin(tx_pin), .rx_pin(rx_pin));

   always #20 aclk = ~aclk;

   // receive pulses and length of the last low run on the tx line
   always @(posedge aclk) begin
      if (rx_irq) irq_n <= irq_n + 1;
      if (!tx_pin) low_run <= low_run + 1;
      else begin
         if (low_run != 0) low_last <= low_run;
         low_run <= 0;
      end
   end

   ////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // bus write: both channels offered together, each released when taken
   task automatic axw(input logic [31:0] a, input logic [31:0] v);
      logic ha, hw, hb;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge aclk);
         ha = awvalid & awready;
         hw = wvalid & wready;
         hb = bvalid;
         @(posedge aclk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) begin
            bready <= 1'b0;
            return;
         end
      end
      chk("write answer", 32'h1, 32'h0);
   endtask

   // bus read, data and response taken at the falling clock edge while rvalid is high
   task automatic axr(input logic [31:0] a);
      logic ha, hb;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge aclk);
         ha = arvalid & arready;
         hb = rvalid;
         d  = rdata;
         r  = rresp;
         @(posedge aclk);
         if (ha) arvalid <= 1'b0;
         if (hb) begin
            rready <= 1'b0;
            return;
         end
      end
      chk("read answer", 32'h1, 32'h0);
   endtask

   task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e);
      axr(a);
      chk(nm, e, d);
   endtask

   task automatic wait_rx(input int k);
      for (int n = 0; n < 2000; n++) begin
         if (i_peer.got.size() >= k) return;
         @(posedge aclk);
      end
      chk("frames seen", 32'(k), 32'(i_peer.got.size()));
   endtask

   ////////////////////////////////////////////////////////////
   // watchdog well beyond the expected few thousand cycles
   initial begin
      #800000;
      bad_count++;
      complete_run();
   end

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata} = {3{32'h00000000}};
      wstrb = 4'hf;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd("status", A_STAT, 32'hd0);
      rd("control", A_CTRL, 32'h0);
      rd("unmapped", 32'h10, 32'h0);
      chk("unmapped resp", 32'h2, {30'h0, r});
      // transmit: idle write, then a write held behind the running frame
      axw(A_CTRL, 32'h407);
      rd("status", A_STAT, 32'hd0);
      axw(A_DATA, 32'h5a);
      rd("status", A_STAT, 32'h90);
      axw(A_DATA, 32'ha5);
      rd("status", A_STAT, 32'h10);
      @(negedge aclk);
      chk("tx_irq", 32'h0, {31'h0, tx_irq});
      @(posedge aclk);
      wait_rx(2);
      repeat (16) @(posedge aclk);
      chk("frame 0", 32'h15a, 32'(i_peer.got[0]));
      chk("frame 1", 32'h1a5, 32'(i_peer.got[1]));
      rd("status", A_STAT, 32'hd0);
      @(negedge aclk);
      chk("tx_irq", 32'h1, {31'h0, tx_irq});
      @(posedge aclk);
      // receive three words unread: third one lost
      axw(A_CTRL, 32'h807);
      n0 = irq_n;
      i_peer.send(8'h3c, 1'b1);
      i_peer.send(8'hc3, 1'b1);
      i_peer.send(8'h99, 1'b1);
      rd("status", A_STAT, 32'hf8);
      rd("data", A_DATA, 32'h3c);
      rd("status", A_STAT, 32'hf0);
      rd("data", A_DATA, 32'hc3);
      rd("status", A_STAT, 32'hd0);
      chk("rx pulses", 32'(n0 + 3), 32'(irq_n));
      // nine-bit word, even parity error, then a received break
      axw(A_CTRL, 32'h80f);
      i_peer.send(8'ha5, 1'b1);
      rd("control", A_CTRL, 32'ha0f);
      rd("status", A_STAT, 32'hf0);
      rd("data", A_DATA, 32'ha5);
      axw(A_CTRL, 32'h817);
      i_peer.send(8'h01, 1'b0);
      rd("status", A_STAT, 32'hf1);
      rd("data", A_DATA, 32'h01);
      axw(A_CTRL, 32'h807);
      i_peer.send(8'h00, 1'b0);
      rd("status", A_STAT, 32'hf4);
      rd("data", A_DATA, 32'h0);
      // low stop bit, then a clean word after the line recovers
      i_peer.send(8'h55, 1'b0);
      rd("status", A_STAT, 32'hf4);
      rd("data", A_DATA, 32'h55);
      i_peer.send(8'h12, 1'b1);
      rd("status", A_STAT, 32'hf0);
      // disable with a word pending
      axw(A_CTRL, 32'h0);
      rd("status", A_STAT, 32'hd0);
      rd("control", A_CTRL, 32'h0);
      // one break, control dropped while it runs
      i_peer.got.delete();
      axw(A_CTRL, 32'h887);
      for (int n = 0; n < 500 && tx_pin; n++) @(posedge aclk);
      axw(A_CTRL, 32'h807);
      wait_rx(1);
      for (int n = 0; n < 500 && !tx_pin; n++) @(posedge aclk);
      repeat (2) @(posedge aclk);
      chk("break low", 32'd224, 32'(low_last));
      chk("break frame", 32'h0, 32'(i_peer.got[0]));
      chk("tx line", 32'h1, {31'h0, tx_pin});
      complete_run();
   end
endmodule
